/* File: logic/nrfbm_pkg.sv */
// Shared constants and types for the NAND read-flow and block-mapping host
package nrfbm_pkg;

  // ------------------------------------------------------------
  // Timing, all at the 20 MHz core clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS         = 50;
  localparam int WE_TO_BUSY_NS         = 200;
  localparam int LAST_OUTPUT_TO_BUSY_NS = 200;
  localparam int CE_HOLD_NS            = 250;
  localparam int CE_TO_DATA_NS         = 55;
  // Least waits round up; strict "more than" figures add one whole cycle
  localparam logic [3:0] WE_TO_BUSY_CYC =
    4'((WE_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] LAST_TO_BUSY_CYC =
    4'((LAST_OUTPUT_TO_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] CE_HOLD_CYC = 4'((CE_HOLD_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS);
  localparam logic [3:0] CE_TO_DATA_CYC = 4'((CE_TO_DATA_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // Array geometry and field positions
  // ------------------------------------------------------------
  localparam int ROW_W       = 13;
  localparam int PAGE_W      = 4;
  localparam int BLK_W       = 9;
  localparam int COL_W       = 9;
  localparam int BLOCK_COUNT = 512;
  localparam int LEN_W       = 16;
  localparam int PASS_FAIL_BIT = 0;
  localparam logic [COL_W-1:0]  LAST_COL       = 9'h107;
  localparam logic [BLK_W-1:0]  SCAN_FIRST_BLK = 9'h001;
  localparam logic [BLK_W-1:0]  SCAN_LAST_BLK  = 9'h1FF;
  localparam logic [PAGE_W-1:0] PAGE_FIRST     = 4'h0;
  localparam logic [LEN_W-1:0]  LEN_ONE        = 16'h0001;

  // ------------------------------------------------------------
  // Data values and command bytes
  // ------------------------------------------------------------
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam logic [7:0] CMD_READ1     = 8'h00;
  localparam logic [7:0] CMD_LOAD      = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_ERASE_SET = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;

  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_SCAN} nrfbm_op_t;

endpackage : nrfbm_pkg

/* File: logic/nrfbm_bad_table.sv */
// Invalid-block table: one bit per block, set on a bad marker or a failed status
`timescale 1ns/100ps
module nrfbm_bad_table #(
  parameter int BLOCKS = nrfbm_pkg::BLOCK_COUNT,
  parameter int BLK_W  = nrfbm_pkg::BLK_W
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             set,
  input  wire logic [BLK_W-1:0] setBlock,
  input  wire logic [BLK_W-1:0] lookBlock,
  output logic                  lookBad
);
  import nrfbm_pkg::*;

  logic [BLOCKS-1:0] bad_q;
  logic [BLOCKS-1:0] bad_d;

  // Next table; a set in the clearing cycle still lands
  always_comb begin
    bad_d = bad_q;
    if (clr) begin
      bad_d = '0;
    end
    if (set) begin
      bad_d[setBlock] = 1'b1;
    end
  end

  // Table storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bad_q <= '0;
    end else begin
      bad_q <= bad_d;
    end
  end

  // Lookup is combinational so a request can be judged on the cycle it arrives
  assign lookBad = bad_q[lookBlock];

endmodule : nrfbm_bad_table

/* File: logic/nrfbm_host.sv */
// Host-side NAND controller: page reads, program, erase, bad-block scan and mapping
// How it works
// - Host ends a sequential read holding chip select high over 250 ns.
// - Host scans markers into a table before any erase, never erasing them.
// - Host refuses program and erase aimed at any listed block.
// - Failed program or erase status bars that block; caller rewrites elsewhere.
// - Read errors go to error correction, never to block replacement.
// - Chip select may rise between bytes; device keeps its read progress.
// - Pass/fail status bit decides whether a program or erase failed.
`timescale 1ns/100ps
module nrfbm_host (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire nrfbm_pkg::nrfbm_op_t        reqOp,
  input  wire logic [nrfbm_pkg::ROW_W-1:0] reqRow,
  input  wire logic [7:0]                  reqCol,
  input  wire logic [nrfbm_pkg::LEN_W-1:0] reqLen,
  input  wire logic [7:0]                  wrData,
  input  wire logic                        wrValid,
  output logic                             wrReady,
  output logic [7:0]                       rdData,
  output logic                             rdValid,
  input  wire logic                        rdReady,
  output logic                             doneValid,
  output logic                             doneFail,
  output logic                             doneRefused,
  output logic                             tableReady,
  output logic                             ceN,
  output logic                             cle,
  output logic                             ale,
  output logic                             weN,
  output logic                             outputStrobeN,
  output logic                             wpN,
  output logic [7:0]                       ioOut,
  output logic                             ioOe,
  input  wire logic [7:0]                  ioIn,
  input  wire logic                        rbN
);
  import nrfbm_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_CMDA, S_ADDR, S_WDATA, S_CMDB, S_BUSY,
    S_STCMD, S_STRD, S_READ, S_GAP, S_CEH, S_DONE
  } nrfbm_state_t;

  // ------------------------------------------------------------
  // Byte selection helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] cmdByte(nrfbm_state_t st, nrfbm_op_t op);
    logic [7:0] b;
    b = CMD_STATUS;
    if (st == S_CMDA) begin
      b = (op == OP_PROG) ? CMD_LOAD : (op == OP_ERASE) ? CMD_ERASE_SET : CMD_READ1;
    end else if (st == S_CMDB) begin
      b = (op == OP_PROG) ? CMD_PROG_GO : CMD_ERASE_GO;
    end
    return b;
  endfunction : cmdByte

  function automatic logic [7:0] addrByte(logic [1:0] idx, logic [ROW_W-1:0] row,
                                          logic [COL_W-1:0] col);
    logic [7:0] b;
    b = col[7:0];
    if (idx == 2'h1) begin
      b = row[7:0];
    end else if (idx == 2'h2) begin
      b = {3'h0, row[ROW_W-1:8]};
    end
    return b;
  endfunction : addrByte

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  nrfbm_state_t     state_q, state_d;
  nrfbm_op_t        op_q, op_d;
  logic             half_q, half_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [LEN_W-1:0] len_q, len_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [1:0]       idx_q, idx_d;
  logic [7:0]       dat_q, dat_d;
  logic [7:0]       rdData_q, rdData_d;
  logic             rdValid_q, rdValid_d;
  logic             tblReady_q, tblReady_d;
  logic             fail_q, fail_d;
  logic             refused_q, refused_d;
  logic             tblSet, tblClr, tblBad;
  logic             stall;
  logic             ceN_q, ceN_d, cle_q, cle_d, ale_q, ale_d;
  logic             weN_q, weN_d, reN_q, reN_d, ioOe_q, ioOe_d;
  logic [7:0]       ioOut_q, ioOut_d;

  nrfbm_bad_table u_table (
    .core_clk  (core_clk),
    .rst       (rst),
    .clr       (tblClr),
    .set       (tblSet),
    .setBlock  (row_q[ROW_W-1:PAGE_W]),
    .lookBlock (reqRow[ROW_W-1:PAGE_W]),
    .lookBad   (tblBad)
  );

  assign stall = rdValid_q && !rdReady;

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q; op_d = op_q; half_d = half_q; row_d = row_q; col_d = col_q;
    len_d = len_q; cnt_d = cnt_q; idx_d = idx_q; dat_d = dat_q; rdData_d = rdData_q;
    rdValid_d = rdValid_q; tblReady_d = tblReady_q; fail_d = fail_q; refused_d = refused_q;
    tblSet = 1'b0;
    tblClr = 1'b0;
    if (rdValid_q && rdReady) begin
      rdValid_d = 1'b0;
    end
    unique case (state_q)
      S_IDLE: begin
        if (reqValid) begin
          op_d = reqOp; row_d = reqRow; col_d = {1'b0, reqCol}; len_d = reqLen;
          idx_d = (reqOp == OP_ERASE) ? 2'h1 : 2'h0;
          half_d = 1'b0; fail_d = 1'b0; refused_d = 1'b0;
          state_d = S_CMDA;
          if (reqOp == OP_SCAN) begin
            row_d = {SCAN_FIRST_BLK, PAGE_FIRST};
            col_d = '0; len_d = LEN_ONE;
            tblReady_d = 1'b0;
            tblClr = 1'b1;
          end else if (reqOp != OP_READ && (!tblReady_q || tblBad)) begin
            refused_d = 1'b1;
            state_d = S_DONE;
          end
        end
      end
      S_CMDA, S_CMDB, S_STCMD: begin
        half_d = !half_q;
        if (half_q) begin
          state_d = (state_q == S_CMDA) ? S_ADDR : (state_q == S_CMDB) ? S_BUSY : S_STRD;
          cnt_d = WE_TO_BUSY_CYC;
        end
      end
      S_ADDR: begin
        half_d = !half_q;
        if (half_q) begin
          idx_d = idx_q + 2'h1;
          if (idx_q == 2'h2) begin
            state_d = (op_q == OP_PROG) ? S_WDATA : (op_q == OP_ERASE) ? S_CMDB : S_BUSY;
            cnt_d = WE_TO_BUSY_CYC;
          end
        end
      end
      S_WDATA: begin
        if (!half_q && len_q == '0) begin
          state_d = S_CMDB;                                              // Strobe high before 10h
        end else if (!half_q && wrValid) begin
          dat_d = wrData;
          half_d = 1'b1;
        end else if (half_q) begin
          half_d = 1'b0;
          len_d = len_q - LEN_ONE;
        end
      end
      S_BUSY: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (rbN) begin
          half_d = 1'b1;
          state_d = (op_q == OP_READ || op_q == OP_SCAN) ? S_READ : S_STCMD;
          if (op_q == OP_PROG || op_q == OP_ERASE) begin
            half_d = 1'b0;
          end
        end
      end
      S_STRD: begin
        half_d = !half_q;
        if (half_q) begin
          fail_d = ioIn[PASS_FAIL_BIT];
          tblSet = ioIn[PASS_FAIL_BIT];
          state_d = S_DONE;
        end
      end
      S_READ: begin
        if (half_q) begin
          half_d = 1'b0;
          if (stall) begin
            state_d = S_GAP;
          end
        end else begin
          len_d = len_q - LEN_ONE;
          col_d = col_q + 9'h001;
          tblSet = (op_q == OP_SCAN) && (ioIn != ERASED_BYTE);
          if (op_q == OP_READ) begin
            rdData_d = ioIn;
            rdValid_d = 1'b1;
          end
          if (len_q == LEN_ONE) begin
            state_d = S_CEH;
            cnt_d = CE_HOLD_CYC - 4'h1;
          end else if (col_q == LAST_COL) begin
            state_d = S_BUSY;
            cnt_d = LAST_TO_BUSY_CYC;
            col_d = '0;
            row_d = row_q + 13'h0001;
          end else begin
            half_d = 1'b1;
          end
        end
      end
      S_GAP: begin
        if (!half_q && !stall) begin
          half_d = 1'b1;
          cnt_d = CE_TO_DATA_CYC - 4'h1;
        end else if (half_q) begin
          if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
          end else begin
            state_d = S_READ;
            half_d = 1'b0;
          end
        end
      end
      S_CEH: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (op_q != OP_SCAN) begin
          state_d = S_DONE;
        end else if (row_q[PAGE_W-1:0] == PAGE_FIRST) begin
          row_d = row_q + 13'h0001;
          col_d = '0; len_d = LEN_ONE; idx_d = 2'h0; half_d = 1'b0;
          state_d = S_CMDA;
        end else if (row_q[ROW_W-1:PAGE_W] == SCAN_LAST_BLK) begin
          tblReady_d = 1'b1;
          state_d = S_DONE;
        end else begin
          row_d = {row_q[ROW_W-1:PAGE_W] + 9'h001, PAGE_FIRST};
          col_d = '0; len_d = LEN_ONE; idx_d = 2'h0; half_d = 1'b0;
          state_d = S_CMDA;
        end
      end
      S_DONE: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Pin values follow the next state so every pin but wpN is a flip-flop
  // ------------------------------------------------------------
  always_comb begin
    ceN_d = (state_d inside {S_IDLE, S_DONE, S_CEH}) || (state_d == S_GAP && !half_d);
    cle_d = state_d inside {S_CMDA, S_CMDB, S_STCMD};
    ale_d = (state_d == S_ADDR);
    weN_d = !(((cle_d || ale_d) && !half_d) || (state_d == S_WDATA && half_d));
    reN_d = !((state_d == S_READ && !half_d) || (state_d == S_STRD && half_d));
    ioOe_d = cle_d || ale_d || (state_d == S_WDATA && half_d);
    ioOut_d = dat_d;
    if (cle_d) begin
      ioOut_d = cmdByte(state_d, op_d);
    end else if (ale_d) begin
      ioOut_d = addrByte(idx_d, row_d, col_d);
    end
  end

  // Registers; pins idle deselected with strobes high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE; op_q <= OP_READ; half_q <= 1'b0; row_q <= '0; col_q <= '0;
      len_q <= '0; cnt_q <= 4'h0; idx_q <= 2'h0; dat_q <= 8'h00; rdData_q <= 8'h00;
      rdValid_q <= 1'b0; tblReady_q <= 1'b0; fail_q <= 1'b0; refused_q <= 1'b0;
      ceN_q <= 1'b1; cle_q <= 1'b0; ale_q <= 1'b0; weN_q <= 1'b1; reN_q <= 1'b1;
      ioOe_q <= 1'b0; ioOut_q <= 8'h00;
    end else begin
      state_q <= state_d; op_q <= op_d; half_q <= half_d; row_q <= row_d; col_q <= col_d;
      len_q <= len_d; cnt_q <= cnt_d; idx_q <= idx_d; dat_q <= dat_d; rdData_q <= rdData_d;
      rdValid_q <= rdValid_d; tblReady_q <= tblReady_d; fail_q <= fail_d;
      refused_q <= refused_d;
      ceN_q <= ceN_d; cle_q <= cle_d; ale_q <= ale_d; weN_q <= weN_d; reN_q <= reN_d;
      ioOe_q <= ioOe_d; ioOut_q <= ioOut_d;
    end
  end

  // Outputs; write protect held off because this host never needs lockout
  assign reqReady = (state_q == S_IDLE);
  assign wrReady = (state_q == S_WDATA) && !half_q && (len_q != '0);
  assign doneValid = (state_q == S_DONE);
  assign doneFail = fail_q;
  assign doneRefused = refused_q;
  assign tableReady = tblReady_q;
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign ceN = ceN_q;
  assign cle = cle_q;
  assign ale = ale_q;
  assign weN = weN_q;
  assign outputStrobeN = reN_q;
  assign wpN = 1'b1;
  assign ioOut = ioOut_q;
  assign ioOe = ioOe_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_hold_start;
    state_q == S_CEH && $past(state_q) != S_CEH;
  endsequence
  sequence s_status_sample;
    state_q == S_STRD && half_q;
  endsequence

  property p_ce_hold;
    s_hold_start |-> ceN [*6];
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("chip select hold too short");

  property p_erase_after_scan;
    (cle && ioOe && ioOut == CMD_ERASE_SET) |-> tblReady_q;
  endproperty
  a_erase_after_scan: assert property (p_erase_after_scan)
    else $error("erase issued before table built");

  property p_refuse_bad;
    (reqValid && reqReady && reqOp != OP_READ && reqOp != OP_SCAN && tblBad)
      |=> (state_q == S_DONE && doneRefused);
  endproperty
  a_refuse_bad: assert property (p_refuse_bad)
    else $error("listed block not refused");

  property p_fail_bars;
    (s_status_sample and ioIn[PASS_FAIL_BIT]) |-> tblSet ##1 (doneFail && doneValid);
  endproperty
  a_fail_bars: assert property (p_fail_bars) else $error("failed block not barred");

  property p_read_no_bar;
    (op_q == OP_READ) |-> !tblSet;
  endproperty
  a_read_no_bar: assert property (p_read_no_bar) else $error("read marked a block");

  property p_gap_resume;
    (state_q == S_GAP && half_q && cnt_q == 4'h0) |=> (!outputStrobeN && !$past(ceN)
      && !$past(ceN, 2));
  endproperty
  a_gap_resume: assert property (p_gap_resume)
    else $error("strobe too soon after select");

  property p_pass_fail;
    s_status_sample |=> (doneValid && doneFail == $past(ioIn[PASS_FAIL_BIT]));
  endproperty
  a_pass_fail: assert property (p_pass_fail) else $error("status bit not reported");

  property p_page_wrap;
    (state_q == S_READ && !half_q && col_q == LAST_COL && len_q != LEN_ONE)
      |=> (state_q == S_BUSY && outputStrobeN) [*5];
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("no wait at page end");

endmodule : nrfbm_host

/* File: verif/nrfbm_flash_model.sv */
// Behavioural model of the flash device facing the host controller
`timescale 1ns/100ps
module nrfbm_flash_model (
  input  wire logic       ceN,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       weN,
  input  wire logic       outputStrobeN,
  input  wire logic [7:0] ioOut,
  input  wire logic       ioOe,
  output logic [7:0]      ioIn,
  output logic            rbN
);
  logic [7:0]  mem [int];
  logic [7:0]  pbuf [int];
  logic [7:0]  cmd, dout;
  logic [12:0] row;
  logic [8:0]  col;
  logic        drv, failNext;
  int          na, busyNs, badErase;

  // Unwritten cells read erased
  function automatic logic [7:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Kept off the clock grid so the host never samples a changing line
  task automatic busy();
    #110 rbN = 1'b0;
    #(busyNs) rbN = 1'b1;
  endtask

  // Factory markers; block 0 carries none
  initial begin
    rbN = 1'b1; drv = 1'b0; dout = 8'h00; cmd = 8'h00;
    busyNs = 150; failNext = 1'b0; badErase = 0; na = 0;
    mem[(3 * 16 + 0) * 512] = 8'h00;
    mem[(5 * 16 + 1) * 512] = 8'h00;
  end

  // Released bus shows the inverse, never a stale value
  assign ioIn = drv ? dout : (ioOe ? ioOut : ~dout);

  // Command, address and data latch on the write strobe
  always @(posedge weN) if (!ceN) begin
    if (cle) begin
      cmd = ioOut;
      na = 0;
      if (ioOut == 8'h10) begin
        foreach (pbuf[k]) mem[int'(row) * 512 + k] = pbuf[k];
        fork busy(); join_none
      end
      if (ioOut == 8'h80) pbuf.delete();
      if (ioOut == 8'hD0) begin
        if (row[12:4] == 9'd3 || row[12:4] == 9'd5) badErase++;
        for (int p = 0; p < 16; p++)
          for (int c = 0; c < 264; c++) mem.delete(int'({row[12:4], 4'(p)}) * 512 + c);
        fork busy(); join_none
      end
    end else if (ale) begin
      if (cmd == 8'h60) begin
        if (na == 0) row[7:0] = ioOut;
        else row[12:8] = ioOut[4:0];
      end else if (na == 0) col = {1'b0, ioOut};
      else if (na == 1) row[7:0] = ioOut;
      else begin
        row[12:8] = ioOut[4:0];
        if (cmd == 8'h00) fork busy(); join_none
      end
      na++;
    end else if (cmd == 8'h80) begin
      pbuf[col] = ioOut;
      col++;
    end
  end

  // Output after the strobe falls; status carries the pass/fail bit
  always @(negedge outputStrobeN) if (!ceN) begin
    #20 drv = 1'b1;
    dout = (cmd == 8'h70) ? {2'b11, 5'b0, failNext} : rd(int'(row) * 512 + col);
  end

  // Column advance survives a chip-select gap; page rolls over
  always @(posedge outputStrobeN) begin
    #15 drv = 1'b0;
    if (cmd == 8'h00) begin
      if (col == 9'd263) begin
        col = 9'd0;
        row++;
        #15 if (!ceN) begin
          rbN = 1'b0;
          #(busyNs) rbN = 1'b1;
        end
        // Deselect stays ready at once, well inside the recovery bound
      end else col++;
    end
  end
endmodule : nrfbm_flash_model

/* File: verif/tb_top.sv */
// Self-checking bench for the host controller against the flash model
`timescale 1ns/100ps
module tb_top;
  import nrfbm_pkg::*;
  logic             core_clk, rst, reqValid, wrValid, rdReady, gotFail, gotRef;
  nrfbm_op_t        reqOp;
  logic [ROW_W-1:0] reqRow;
  logic [7:0]       reqCol, wrData, rdData, ioOut, ioIn;
  logic [LEN_W-1:0] reqLen;
  logic             reqReady, wrReady, rdValid, doneValid, doneFail, doneRefused;
  logic             tableReady, ceN, cle, ale, weN, outputStrobeN, ioOe, rbN;
  int               errCount, compares;
  logic [7:0]       wq[$], rdq[$];

  nrfbm_host nrfbm_host_i (.core_clk, .rst, .reqValid, .reqReady, .reqOp, .reqRow,
    .reqCol, .reqLen, .wrData, .wrValid, .wrReady, .rdData, .rdValid, .rdReady,
    .doneValid, .doneFail, .doneRefused, .tableReady, .ceN, .cle, .ale, .weN,
    .outputStrobeN, .wpN(), .ioOut, .ioOe, .ioIn, .rbN);
  nrfbm_flash_model nrfbm_flash_model_i (.ceN, .cle, .ale, .weN, .outputStrobeN,
    .ioOut, .ioOe, .ioIn, .rbN);

  // ------------------------------------------------------------
  // Checking and ending
  // ------------------------------------------------------------
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkByte

  task automatic chkFlag(input logic got, input logic exp);
    chkByte({7'h00, got}, {7'h00, exp});
  endtask : chkFlag

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, errCount);
    if (errCount == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // One request, streaming wq out and rdq in; stall holds rdReady low
  task automatic run(input nrfbm_op_t op, input logic [12:0] row, input logic [7:0] col,
                     input logic [15:0] len, input int stall);
    int  wi, sc;
    logic tw, tr;
    wi = 0; sc = 0; rdq.delete();
    @(posedge core_clk);
    reqValid <= 1'b1; reqOp <= op; reqRow <= row; reqCol <= col; reqLen <= len;
    wrValid <= (wq.size() > 0); wrData <= (wq.size() > 0) ? wq[0] : 8'h00;
    @(posedge core_clk);
    reqValid <= 1'b0;
    forever begin
      @(negedge core_clk);
      if (doneValid === 1'b1) break;
      tw = wrValid && (wrReady === 1'b1);
      tr = (rdValid === 1'b1) && rdReady;
      if (tr) rdq.push_back(rdData);
      @(posedge core_clk);
      if (tw) begin
        wi++;
        wrValid <= (wi < wq.size());
        wrData <= (wi < wq.size()) ? wq[wi] : 8'h00;
      end
      if (tr && stall > 0) begin
        rdReady <= 1'b0;
        sc = stall;
      end else if (sc > 0) begin
        sc--;
        if (sc == 0) rdReady <= 1'b1;
      end
    end
    gotFail = doneFail;
    gotRef = doneRefused;
    wq.delete();
  endtask : run

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_early();
    wq = '{8'h11};
    run(OP_PROG, 13'h0020, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b1);
    chkFlag(tableReady, 1'b0);
    $display("test early done");
  endtask : t_early

  task automatic t_scan();
    run(OP_SCAN, 13'h0000, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b0);
    chkFlag(tableReady, 1'b1);
    $display("test scan done");
  endtask : t_scan

  task automatic t_listed();
    run(OP_ERASE, {9'd3, 4'h0}, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b1);
    wq = '{8'h22};
    run(OP_PROG, {9'd5, 4'h2}, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b1);
    run(OP_ERASE, {9'd4, 4'h0}, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b0);
    chkFlag(gotFail, 1'b0);
    chkByte(8'(nrfbm_flash_model_i.badErase), 8'h00);
    $display("test listed done");
  endtask : t_listed

  task automatic t_erased();
    nrfbm_flash_model_i.busyNs = 9500;
    run(OP_READ, 13'h0000, 8'h0A, 16'h0002, 0);
    nrfbm_flash_model_i.busyNs = 150;
    chkByte(8'(rdq.size()), 8'h02);
    foreach (rdq[i]) chkByte(rdq[i], 8'hFF);
    $display("test erased done");
  endtask : t_erased

  task automatic t_rows();
    logic [7:0] e;
    wq = '{8'hA1, 8'hB2};
    run(OP_PROG, 13'h0002, 8'hFE, 16'h0002, 0);
    chkFlag(gotFail, 1'b0);
    wq = '{8'h5A};
    run(OP_PROG, 13'h0003, 8'h00, 16'h0001, 0);
    run(OP_READ, 13'h0002, 8'hFE, 16'h000B, 3);
    chkByte(8'(rdq.size()), 8'h0B);
    for (int i = 0; i < 11; i++) begin
      e = (i == 0) ? 8'hA1 : (i == 1) ? 8'hB2 : (i == 10) ? 8'h5A : 8'hFF;
      chkByte(rdq[i], e);
    end
    $display("test rows done");
  endtask : t_rows

  task automatic t_fail();
    nrfbm_flash_model_i.failNext = 1'b1;
    wq = '{8'h33};
    run(OP_PROG, {9'd7, 4'h0}, 8'h00, 16'h0001, 0);
    nrfbm_flash_model_i.failNext = 1'b0;
    chkFlag(gotFail, 1'b1);
    run(OP_ERASE, {9'd7, 4'h0}, 8'h00, 16'h0001, 0);
    chkFlag(gotRef, 1'b1);
    $display("test fail done");
  endtask : t_fail

  // ------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    errCount = 0; compares = 0; rst = 1'b1; reqValid = 1'b0; reqOp = OP_READ;
    reqRow = 13'h0000; reqCol = 8'h00; reqLen = 16'h0001;
    wrData = 8'h00; wrValid = 1'b0; rdReady = 1'b1;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_early();
    t_scan();
    t_listed();
    t_erased();
    t_rows();
    t_fail();
    summarize();
  end

  // Scan dominates the run time; this leaves ample margin
  initial begin
    #4000000;
    errCount++;
    summarize();
  end
endmodule : tb_top
